// ---- design/pwm_output_stage_control.v ----
// PWM output stage: dead-time, mask, fault brake, polarity.
// Assumes an Avalon-MM master and raw waves on ref_clk.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "pwm_out_map.vh"

// Notes on behaviour
// - One dead-time enable bit per pair
// - Dead-time delays both rising and falling edges
// - Enables count only in complementary mode
// - Nine-bit length, msb in enable register
// - Length applied when complementary and enabled
// - Dead-time registers need timed access
// - Mode zero drives all channels independently
// - Synchronous odd channels copy even partner
// - Per-channel mask selects generator or level
// - Masked channel drives its mask level
// - Mask enables reset to zero
// - Masked level still passes polarity inversion
// - Fault pin acts only when enabled
// - Fault brake overrides channels with levels
// - Fault brake clears generator run bit
// - Fault brake zeroes the sixteen-bit counter
// - Fault brake sets flag and requests interrupt
// - Override holds until run set again
// - Edge select picks falling or rising
// - Fault pin debounced eight clocks
// - ADC compare event brakes the same way
// - Per-channel polarity, active high default
// - Polarity bit set inverts the pin
// - Mode one selects complementary
// - Complementary odd is inverse of even
// - Dead-time down-counter released on reaching zero
module pwm_output_stage_control #(
  parameter CHANNELS = 6,
  parameter LEN_W    = 9
) (
  input  wire                ref_clk,
  input  wire                rst_n,
  input  wire [9:0]          address,
  input  wire                read,
  input  wire                write,
  input  wire [3:0]          byteenable,
  input  wire [31:0]         writedata,
  output reg  [31:0]         readdata,
  output wire                waitrequest,
  input  wire [CHANNELS-1:0] raw_channel_wave,
  input  wire                fault_input_pin,
  input  wire                adc_compare_event,
  input  wire                timed_access_unlock,
  output reg  [CHANNELS-1:0] pwm_pin,
  output wire                generator_run,
  output reg                 counter_clear,
  output wire                fault_irq_req,
  output wire [7:0]          pwm_control_one_bits
);

  // ======================================================
  // Register storage
  reg [7:0]          pwm_control_zero;
  reg [7:0]          pwm_control_one;
  reg [CHANNELS-1:0] fault_override_levels;
  reg                fault_edge_select;
  reg                fault_event_flag;
  reg [2:0]          dead_time_enables;
  reg                dead_time_msb;
  reg [7:0]          dead_time_length;
  reg [CHANNELS-1:0] channel_mask_enables;
  reg [CHANNELS-1:0] channel_mask_levels;
  reg [CHANNELS-1:0] output_invert_bits;

  // ======================================================
  // Bus slave state
  reg                ack;
  reg [31:0]         next_readdata;
  wire               req;
  wire               wr_take;
  wire               lane0;
  wire [7:0]         idx;
  wire [7:0]         wbyte;

  // ======================================================
  // Fault path state
  reg                pin_s1;
  reg                pin_s2;
  reg                pin_s3;
  reg                pin_level;
  reg                pin_stable;
  reg [3:0]          stable_cnt;
  reg                pin_filt;
  reg                pin_filt_d;
  reg                brake_active;
  wire               pin_event;
  wire               fault_event;
  wire               run_written;

  // ======================================================
  // Datapath wires
  wire [1:0]         output_mode_field;
  wire               comp_mode;
  wire               sync_mode;
  wire [LEN_W-1:0]   full_length;
  wire [CHANNELS-1:0] staged;
  reg  [CHANNELS-1:0] next_pin;

  // ======================================================
  // Avalon-MM handshake: one wait state per access
  assign req         = read | write;
  assign waitrequest = req & ~ack;
  assign wr_take     = write & ack;
  assign lane0       = byteenable[0];
  assign idx         = address[9:2];
  assign wbyte       = writedata[7:0];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ======================================================
  // Read mux, unmapped reads return zero
  always @* begin
    next_readdata = 32'h00000000;
    case (idx)
      `IDX_OUTPUT_INVERT: begin
        next_readdata[CHANNELS-1:0] = output_invert_bits;
      end
      `IDX_FAULT_BRAKE_DATA: begin
        next_readdata[7:0] = {fault_event_flag, fault_edge_select,
                              fault_override_levels};
      end
      `IDX_PWM_CONTROL_ZERO: begin
        next_readdata[7:0] = pwm_control_zero;
      end
      `IDX_PWM_CONTROL_ONE: begin
        next_readdata[7:0] = pwm_control_one;
      end
      `IDX_DEAD_TIME_ENABLE: begin
        next_readdata[`FLD_DEAD_TIME_MSB] = dead_time_msb;
        next_readdata[`FLD_PAIR_EN_HI:0]  = dead_time_enables;
      end
      `IDX_DEAD_TIME_COUNT: begin
        next_readdata[7:0] = dead_time_length;
      end
      `IDX_MASK_ENABLE: begin
        next_readdata[CHANNELS-1:0] = channel_mask_enables;
      end
      `IDX_MASK_LEVEL: begin
        next_readdata[CHANNELS-1:0] = channel_mask_levels;
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h00000000;
    end else if (read && !ack) begin
      readdata <= next_readdata;
    end
  end

  // ======================================================
  // Plain read/write registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_control_one      <= `RST_BYTE;
      channel_mask_enables <= `RST_CHANNELS;
      channel_mask_levels  <= `RST_CHANNELS;
      output_invert_bits   <= `RST_CHANNELS;
    end else if (wr_take && lane0) begin
      case (idx)
        `IDX_PWM_CONTROL_ONE: begin
          pwm_control_one <= wbyte;
        end
        `IDX_MASK_ENABLE: begin
          channel_mask_enables <= wbyte[CHANNELS-1:0];
        end
        `IDX_MASK_LEVEL: begin
          channel_mask_levels <= wbyte[CHANNELS-1:0];
        end
        `IDX_OUTPUT_INVERT: begin
          output_invert_bits <= wbyte[CHANNELS-1:0];
        end
        default: begin
          output_invert_bits <= output_invert_bits;
        end
      endcase
    end
  end

  // ======================================================
  // Timed-access protected dead-time registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dead_time_enables <= `RST_PAIRS;
      dead_time_msb     <= 1'b0;
      dead_time_length  <= `RST_BYTE;
    end else if (wr_take && lane0 && timed_access_unlock) begin
      if (idx == `IDX_DEAD_TIME_ENABLE) begin
        dead_time_enables <= wbyte[`FLD_PAIR_EN_HI:0];
        dead_time_msb     <= wbyte[`FLD_DEAD_TIME_MSB];
      end
      if (idx == `IDX_DEAD_TIME_COUNT) begin
        dead_time_length <= wbyte;
      end
    end
  end

  // ======================================================
  // Fault pin: three-flop sync, eight-clock debounce
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1     <= 1'b1;
      pin_s2     <= 1'b1;
      pin_s3     <= 1'b1;
      pin_level  <= 1'b1;
      pin_stable <= 1'b1;
      stable_cnt <= 4'h0;
      pin_filt   <= 1'b1;
      pin_filt_d <= 1'b1;
    end else begin
      pin_s1 <= fault_input_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
      if (pin_level != pin_stable) begin
        pin_stable <= pin_level;
        stable_cnt <= 4'h1;
      end else if (stable_cnt < `DEBOUNCE_CYCLES) begin
        stable_cnt <= stable_cnt + 4'h1;
      end else begin
        pin_filt <= pin_stable;
      end
      pin_filt_d <= pin_filt;
    end
  end

  // Falling when select is 0, rising when 1
  assign pin_event = pwm_control_one[`FLD_FAULT_PIN_EN] &
                     (fault_edge_select ?
                      (pin_filt & ~pin_filt_d) :
                      (~pin_filt & pin_filt_d));

  // ADC compare brakes the same way
  assign fault_event = pin_event | adc_compare_event;

  // ======================================================
  // Fault brake data, flag and run bit
  assign run_written = wr_take && lane0 &&
                       (idx == `IDX_PWM_CONTROL_ZERO) &&
                       wbyte[`FLD_RUN];

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_override_levels <= `RST_CHANNELS;
      fault_edge_select     <= 1'b0;
      fault_event_flag      <= 1'b0;
    end else begin
      if (wr_take && lane0 && (idx == `IDX_FAULT_BRAKE_DATA)) begin
        fault_override_levels <= wbyte[CHANNELS-1:0];
        fault_edge_select     <= wbyte[`FLD_FAULT_EDGE_SEL];
        if (!wbyte[`FLD_FAULT_FLAG]) begin
          fault_event_flag <= 1'b0;
        end
      end
      if (fault_event) begin
        fault_event_flag <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_control_zero <= `RST_BYTE;
      brake_active     <= 1'b0;
      counter_clear    <= 1'b0;
    end else begin
      counter_clear <= fault_event;
      if (fault_event) begin
        pwm_control_zero[`FLD_RUN] <= 1'b0;
        brake_active               <= 1'b1;
      end else if (wr_take && lane0 &&
                   (idx == `IDX_PWM_CONTROL_ZERO)) begin
        pwm_control_zero <= wbyte;
        if (run_written) begin
          brake_active <= 1'b0;
        end
      end
    end
  end

  // Pulse clears the external 16-bit counter
  assign generator_run        = pwm_control_zero[`FLD_RUN];
  assign fault_irq_req        = fault_event_flag;
  assign pwm_control_one_bits = pwm_control_one;

  // ======================================================
  // Mode and dead-time stage, one instance per pair
  assign output_mode_field = pwm_control_one[`FLD_MODE_HI:`FLD_MODE_LO];
  assign comp_mode   = (output_mode_field == `MODE_COMPLEMENTARY);
  assign sync_mode   = (output_mode_field == `MODE_SYNCHRONOUS);
  assign full_length = {dead_time_msb, dead_time_length};

  genvar p;
  generate
    for (p = 0; p < CHANNELS/2; p = p + 1) begin : pair
      dead_time_pair #(
        .LEN_W(LEN_W)
      ) u_pair (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .comp_mode        (comp_mode),
        .sync_mode        (sync_mode),
        .delay_en         (dead_time_enables[p]),
        .dead_time_length (full_length),
        .raw_even         (raw_channel_wave[2*p]),
        .raw_odd          (raw_channel_wave[2*p+1]),
        .out_even         (staged[2*p]),
        .out_odd          (staged[2*p+1])
      );
    end
  endgenerate

  // ======================================================
  // Override and polarity
  integer c;
  always @* begin
    next_pin = {CHANNELS{1'b0}};
    for (c = 0; c < CHANNELS; c = c + 1) begin
      if (brake_active) begin
        next_pin[c] = fault_override_levels[c];
      end else if (channel_mask_enables[c]) begin
        next_pin[c] = channel_mask_levels[c];
      end else begin
        next_pin[c] = staged[c];
      end
      next_pin[c] = next_pin[c] ^ output_invert_bits[c];
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_pin <= {CHANNELS{1'b0}};
    end else begin
      pwm_pin <= next_pin;
    end
  end

endmodule

// ---- include/pwm_out_map.vh ----
// Register map and constants of the PWM output stage.
// Assumes a 32-bit Avalon-MM bus, one register per aligned word.
`ifndef PWM_OUT_MAP_VH
`define PWM_OUT_MAP_VH

// ========================================================
// Register indices (byte address is four times the index)
`define IDX_OUTPUT_INVERT      8'hD6
`define IDX_FAULT_BRAKE_DATA   8'hD7
`define IDX_PWM_CONTROL_ZERO   8'hD8
`define IDX_PWM_CONTROL_ONE    8'hDF
`define IDX_DEAD_TIME_ENABLE   8'hF9
`define IDX_DEAD_TIME_COUNT    8'hFA
`define IDX_MASK_ENABLE        8'hFB
`define IDX_MASK_LEVEL         8'hFC

// ========================================================
// Reset values
`define RST_BYTE               8'h00
`define RST_CHANNELS           6'h00
`define RST_PAIRS              3'h0

// ========================================================
// Field positions
`define FLD_FAULT_FLAG         7
`define FLD_FAULT_EDGE_SEL     6
`define FLD_RUN                7
`define FLD_MODE_HI            7
`define FLD_MODE_LO            6
`define FLD_FAULT_PIN_EN       3
`define FLD_DEAD_TIME_MSB      4
`define FLD_PAIR_EN_HI         2

// ========================================================
// Output mode encodings
`define MODE_INDEPENDENT       2'h0
`define MODE_COMPLEMENTARY     2'h1
`define MODE_SYNCHRONOUS       2'h2

// ========================================================
// Timing counts
`define DEBOUNCE_CYCLES        4'h8

`endif

// ---- design/dead_time_pair.v ----
// One channel pair: mode copy and dead-time delay on both edges of the even wave.
// Assumes raw waves on the same clock; outputs lag by one cycle.
`timescale 1ns/1ns
`include "pwm_out_map.vh"

module dead_time_pair #(
  parameter LEN_W = 9
) (
  input  wire             ref_clk,
  input  wire             rst_n,
  input  wire             comp_mode,
  input  wire             sync_mode,
  input  wire             delay_en,
  input  wire [LEN_W-1:0] dead_time_length,
  input  wire             raw_even,
  input  wire             raw_odd,
  output reg              out_even,
  output reg              out_odd
);

  reg             even_d;
  reg             busy;
  reg [LEN_W-1:0] count;
  wire            delay_on;
  wire            next_even;
  wire            next_odd;

  // ======================================================
  // Shared down-counter per pair
  // Delay only with complementary and enable
  assign delay_on = comp_mode & delay_en;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      even_d <= 1'b0;
      busy   <= 1'b0;
      count  <= {LEN_W{1'b0}};
    end else begin
      even_d <= raw_even;
      // Load on edge, release on reaching zero
      if (delay_on && (raw_even != even_d)) begin
        busy  <= 1'b1;
        count <= dead_time_length;
      end else if (busy) begin
        if (count == {LEN_W{1'b0}}) begin
          busy <= 1'b0;
        end else begin
          count <= count - {{(LEN_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ======================================================
  // Mode selection
  // Even channel as independent
  assign next_even = raw_even;
  // Odd is in-phase copy in synchronous
  assign next_odd  = comp_mode ? ~raw_even :
                     sync_mode ? raw_even : raw_odd;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_even <= 1'b0;
      out_odd  <= 1'b0;
    end else if (delay_on && (busy || (raw_even != even_d))) begin
      out_even <= 1'b0;
      out_odd  <= 1'b0;
    end else begin
      // Cleared or ignored enable: no delay
      out_even <= next_even;
      out_odd  <= next_odd;
    end
  end

endmodule

// ---- bench/pwm_stage_checker_sva.sv ----
// Port-level checker for the PWM output stage.
// Assumes one clock domain and the active-low reset.
`timescale 1ns/1ns
`include "pwm_out_map.vh"

module pwm_stage_checker #(
  parameter CHANNELS = 6,
  parameter LEN_W    = 9
) (
  input wire                ref_clk,
  input wire                rst_n,
  input wire [9:0]          address,
  input wire                read,
  input wire                write,
  input wire [3:0]          byteenable,
  input wire [31:0]         writedata,
  input wire [31:0]         readdata,
  input wire                waitrequest,
  input wire [CHANNELS-1:0] raw_channel_wave,
  input wire                fault_input_pin,
  input wire                adc_compare_event,
  input wire                timed_access_unlock,
  input wire [CHANNELS-1:0] pwm_pin,
  input wire                generator_run,
  input wire                counter_clear,
  input wire                fault_irq_req,
  input wire [7:0]          pwm_control_one_bits
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ========================================================
  // Cycles since the fault pin last changed
  reg [5:0] pin_age;
  reg       pin_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_age <= 6'h00;
      pin_q   <= 1'b1;
    end else begin
      pin_q <= fault_input_pin;
      if (fault_input_pin != pin_q)
        pin_age <= 6'h00;
      else if (pin_age != 6'h3F)
        pin_age <= pin_age + 6'h01;
    end
  end

  wire take = write && !waitrequest && byteenable[0];

  sequence s_wait;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_brake;
    fault_irq_req && !generator_run && counter_clear ##1 !counter_clear;
  endsequence

  // ========================================================
  // Assertions
  chk_bus_wait: assert property ($rose(read || write) |-> s_wait)
    else $error("waitrequest not one cycle");
  chk_read_upper: assert property (
    read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("readdata upper bits set");
  chk_adc_brake: assert property (adc_compare_event |=> s_brake)
    else $error("compare event did not brake");
  chk_clear_cause: assert property (
    counter_clear |-> fault_irq_req && !generator_run)
    else $error("counter clear without brake");
  chk_run_release: assert property (
    $rose(generator_run) |-> $past(take &&
      address[9:2] == `IDX_PWM_CONTROL_ZERO && writedata[7]))
    else $error("run rose without a write");
  chk_flag_sticky: assert property (
    fault_irq_req && !(take && address[9:2] == `IDX_FAULT_BRAKE_DATA &&
      !writedata[7]) |=> fault_irq_req)
    else $error("fault flag dropped by itself");
  chk_flag_debounce: assert property (
    $rose(fault_irq_req) && !$past(adc_compare_event) |->
      pin_age >= 6'h06 && pin_age <= 6'h18)
    else $error("pin fault not debounced");
  chk_brake_hold: assert property (
    fault_irq_req && !generator_run && $past(fault_irq_req, 2) &&
      !$past(write) && !$past(write, 2) |-> $stable(pwm_pin))
    else $error("pins moved during brake");
endmodule

// ---- bench/power_stage_model.sv ----
// Power stage switches and fault source beside the output stage.
// Assumes active-high switches and a fault pin idle high.
`timescale 1ns/1ns

module power_stage_model (
  input  wire       ref_clk,
  input  wire [5:0] pwm_pin,
  output reg        fault_input_pin
);
  integer shoot_through;

  initial begin
    fault_input_pin = 1'b1;
    shoot_through = 0;
  end

  // Both switches of pair zero on
  always @(posedge ref_clk) begin
    if (pwm_pin[0] && pwm_pin[1])
      shoot_through <= shoot_through + 1;
  end

  // Fault held low for len clocks
  task pulse(input integer len);
    begin
      @(posedge ref_clk);
      fault_input_pin <= 1'b0;
      repeat (len) @(posedge ref_clk);
      fault_input_pin <= 1'b1;
    end
  endtask
endmodule

// ---- bench/pwm_output_stage_control_test.sv ----
// Self-checking bench for the PWM output stage.
// Assumes the design's register map header on the include path.
`timescale 1ns/1ns
`include "pwm_out_map.vh"
`define CHECK(got, exp) begin comparisons = comparisons + 1; \
  if ((got) !== (exp)) begin mismatches = mismatches + 1; \
  $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); end end

module pwm_output_stage_control_test;
  reg         ref_clk, rst_n, read, write, adc, unlock;
  reg  [9:0]  address;
  reg  [3:0]  byteenable;
  reg  [31:0] writedata;
  reg  [5:0]  raw;
  wire [31:0] readdata;
  wire [5:0]  pwm_pin;
  wire [7:0]  ctl_one;
  wire        waitrequest, generator_run, counter_clear, flag, fpin;
  integer     mismatches, comparisons, cycles;

  pwm_output_stage_control #(.CHANNELS(6), .LEN_W(9)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .raw_channel_wave(raw), .fault_input_pin(fpin),
    .adc_compare_event(adc), .timed_access_unlock(unlock),
    .pwm_pin(pwm_pin), .generator_run(generator_run),
    .counter_clear(counter_clear), .fault_irq_req(flag),
    .pwm_control_one_bits(ctl_one));
  power_stage_model i_stage (
    .ref_clk(ref_clk), .pwm_pin(pwm_pin), .fault_input_pin(fpin));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      test_done;
    end
  end

  // ========================================================
  // Bus and pin helpers
  task bus_write(input [7:0] idx, input [7:0] d);
    begin
      address <= {idx, 2'h0};
      writedata <= {24'h000000, d};
      write <= 1'b1;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0) @(posedge ref_clk);
      write <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task bus_read(input [7:0] idx, output [7:0] d);
    begin
      address <= {idx, 2'h0};
      read <= 1'b1;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0) @(posedge ref_clk);
      d = readdata[7:0];
      read <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task ta_write(input [7:0] idx, input [7:0] d);
    begin
      unlock <= 1'b1;
      bus_write(idx, d);
      unlock <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task check_pins(input [5:0] exp);
    begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHECK(pwm_pin, exp)
      @(posedge ref_clk);
    end
  endtask
  function [5:0] mode_out(input [1:0] m, input [5:0] r);
    integer i;
    begin
      mode_out = r;
      for (i = 1; i < 6; i = i + 2) begin
        if (m == 2'h1) mode_out[i] = ~r[i-1];
        if (m == 2'h2) mode_out[i] = r[i-1];
      end
    end
  endfunction

  // ========================================================
  // Scenarios
  task t_reset;
    reg [63:0] map;
    reg [7:0]  d;
    integer    i;
    begin
      map = {`IDX_OUTPUT_INVERT, `IDX_FAULT_BRAKE_DATA, `IDX_PWM_CONTROL_ZERO,
             `IDX_PWM_CONTROL_ONE, `IDX_DEAD_TIME_ENABLE,
             `IDX_DEAD_TIME_COUNT, `IDX_MASK_ENABLE, `IDX_MASK_LEVEL};
      for (i = 0; i < 8; i = i + 1) begin
        bus_read(map[i*8 +: 8], d);
        `CHECK(d, 8'h00)
      end
      bus_write(8'h10, 8'hA5);
      bus_read(8'h10, d);
      `CHECK(d, 8'h00)
      // Write with lane 0 disabled is ignored
      byteenable <= 4'hE;
      bus_write(`IDX_MASK_ENABLE, 8'h3F);
      byteenable <= 4'hF;
      bus_read(`IDX_MASK_ENABLE, d);
      `CHECK(d, 8'h00)
      `CHECK(generator_run, 1'b0)
    end
  endtask

  task t_modes;
    integer m;
    begin
      ta_write(`IDX_DEAD_TIME_COUNT, 8'h20);
      ta_write(`IDX_DEAD_TIME_ENABLE, 8'h07);
      bus_write(`IDX_OUTPUT_INVERT, 8'h21);
      for (m = 0; m < 4; m = m + 1) begin
        if (m == 1)
          ta_write(`IDX_DEAD_TIME_ENABLE, 8'h00);
        bus_write(`IDX_PWM_CONTROL_ONE, {m[1:0], 6'h00});
        `CHECK(ctl_one, {m[1:0], 6'h00})
        raw <= 6'h19;
        check_pins(mode_out(m[1:0], 6'h19) ^ 6'h21);
        raw <= 6'h26;
        check_pins(mode_out(m[1:0], 6'h26) ^ 6'h21);
      end
      bus_write(`IDX_PWM_CONTROL_ONE, 8'h00);
      bus_write(`IDX_MASK_ENABLE, 8'h2A);
      bus_write(`IDX_MASK_LEVEL, 8'h0F);
      raw <= 6'h19;
      check_pins(6'h3A);
      bus_write(`IDX_MASK_ENABLE, 8'h00);
      bus_write(`IDX_OUTPUT_INVERT, 8'h00);
    end
  endtask

  task t_dead;
    reg [7:0] d;
    integer   s;
    begin
      bus_write(`IDX_DEAD_TIME_COUNT, 8'hFF);
      bus_read(`IDX_DEAD_TIME_COUNT, d);
      `CHECK(d, 8'h20)
      ta_write(`IDX_DEAD_TIME_COUNT, 8'h04);
      ta_write(`IDX_DEAD_TIME_ENABLE, 8'h11);
      bus_read(`IDX_DEAD_TIME_ENABLE, d);
      `CHECK(d, 8'h11)
      bus_write(`IDX_PWM_CONTROL_ONE, 8'h40);
      raw <= 6'h00;
      repeat (280) @(posedge ref_clk);
      s = i_stage.shoot_through;
      raw <= 6'h05;
      check_pins(6'h24);
      repeat (250) @(posedge ref_clk);
      check_pins(6'h24);
      repeat (10) @(posedge ref_clk);
      check_pins(6'h25);
      raw <= 6'h00;
      check_pins(6'h28);
      repeat (270) @(posedge ref_clk);
      check_pins(6'h2A);
      `CHECK(i_stage.shoot_through, s)
      ta_write(`IDX_DEAD_TIME_ENABLE, 8'h00);
      bus_write(`IDX_PWM_CONTROL_ONE, 8'h00);
    end
  endtask

  task t_adc;
    begin
      bus_write(`IDX_OUTPUT_INVERT, 8'h03);
      bus_write(`IDX_FAULT_BRAKE_DATA, 8'h15);
      bus_write(`IDX_PWM_CONTROL_ZERO, 8'h80);
      `CHECK(generator_run, 1'b1)
      bus_write(`IDX_MASK_ENABLE, 8'h3F);
      raw <= 6'h3F;
      check_pins(6'h0C);
      adc <= 1'b1;
      @(posedge ref_clk);
      adc <= 1'b0;
      @(negedge ref_clk);
      `CHECK(flag, 1'b1)
      `CHECK(generator_run, 1'b0)
      `CHECK(counter_clear, 1'b1)
      @(negedge ref_clk);
      `CHECK(counter_clear, 1'b0)
      @(posedge ref_clk);
      check_pins(6'h16);
      raw <= 6'h00;
      bus_write(`IDX_FAULT_BRAKE_DATA, 8'h15);
      `CHECK(flag, 1'b0)
      check_pins(6'h16);
      bus_write(`IDX_PWM_CONTROL_ZERO, 8'h00);
      check_pins(6'h16);
      bus_write(`IDX_MASK_ENABLE, 8'h00);
      bus_write(`IDX_PWM_CONTROL_ZERO, 8'h80);
      check_pins(6'h03);
      bus_write(`IDX_OUTPUT_INVERT, 8'h00);
    end
  endtask

  task t_pin;
    begin
      bus_write(`IDX_PWM_CONTROL_ONE, 8'h08);
      bus_write(`IDX_FAULT_BRAKE_DATA, 8'h2A);
      i_stage.pulse(4);
      repeat (30) @(posedge ref_clk);
      `CHECK(flag, 1'b0)
      i_stage.pulse(20);
      repeat (30) @(posedge ref_clk);
      `CHECK(flag, 1'b1)
      `CHECK(generator_run, 1'b0)
      bus_write(`IDX_FAULT_BRAKE_DATA, 8'h6A);
      bus_write(`IDX_PWM_CONTROL_ZERO, 8'h80);
      i_stage.pulse(20);
      `CHECK(flag, 1'b0)
      repeat (30) @(posedge ref_clk);
      `CHECK(flag, 1'b1)
      bus_write(`IDX_PWM_CONTROL_ONE, 8'h00);
      bus_write(`IDX_FAULT_BRAKE_DATA, 8'h2A);
      bus_write(`IDX_PWM_CONTROL_ZERO, 8'h80);
      i_stage.pulse(20);
      repeat (30) @(posedge ref_clk);
      `CHECK(flag, 1'b0)
    end
  endtask

  initial begin
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    adc = 1'b0;
    unlock = 1'b0;
    byteenable = 4'hF;
    address = 10'h000;
    writedata = 32'h00000000;
    raw = 6'h00;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_modes;
    t_dead;
    t_adc;
    t_pin;
    test_done;
  end
endmodule

bind pwm_output_stage_control pwm_stage_checker #(
  .CHANNELS(CHANNELS), .LEN_W(LEN_W)) i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .raw_channel_wave(raw_channel_wave), .fault_input_pin(fault_input_pin),
  .adc_compare_event(adc_compare_event),
  .timed_access_unlock(timed_access_unlock), .pwm_pin(pwm_pin),
  .generator_run(generator_run), .counter_clear(counter_clear),
  .fault_irq_req(fault_irq_req),
  .pwm_control_one_bits(pwm_control_one_bits));
